// File: include/sppc_regs.vh
`ifndef SPPC_REGS_VH
`define SPPC_REGS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SPPC_CTRL_OFS     4'h0
`define SPPC_STATUS_OFS   4'h4
`define SPPC_RXWORD_OFS   4'h8
`define SPPC_PERIOD_OFS   4'hc

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SPPC_CTRL_RX_RATE 0
`define SPPC_CTRL_TX_RATE 1
`define SPPC_CTRL_ALIGN   2
`define SPPC_CTRL_LOOP    3
`define SPPC_CTRL_FLOSS   4
`define SPPC_CTRL_W       5
`define SPPC_CTRL_RST     5'h00

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define SPPC_ST_LOSS      0
`define SPPC_ST_FULL      1
`define SPPC_ST_EMPTY     2
`define SPPC_ST_OVF_LSB   8

// ----------------------------------------------------------------
// Line constants
// ----------------------------------------------------------------
`define SPPC_WORD_W       10
`define SPPC_BIT_MULT     20
`define SPPC_PAIRS_PER_PD 16'h000a
`define SPPC_ALL_ONES     10'h3ff
`define SPPC_LOS_CYCLES   64
`define SPPC_RBC_HALF     8

`endif

// File: verilog/sppc_top.v
// Contract
// [R1] Rx rate low: one bit per pair, words presented only on clock A rising edge.
// [R2] Rx rate high: both bits per pair, words presented on A and B rises alternately.
// [R3] Alignment mode one: rx word changes with its clock edge, like transmit.
// [R4] While signal loss is flagged, every received word bit reads one.
// [R5] Loop enable high: serial output held static at ones.
// [R6] Serial input used, and serial output driven, only with loop enable low.
// [R7] Sender launches on both byte clock edges; window derived from both edges.
// [R8] Serial bit rate is twenty times the transmit byte clock rate; with Tx rate low the serializer sends ten bits per byte clock period.
// [R9] Two recovered byte clocks are kept in opposite phase.
// [R10] Host supplies the receive reference clock, differential or single-ended.
// [R11] Transmit bit zero is least significant and sent first.
// [R12] Received word holds one 10-bit character, bit zero received first.
// [R13] Loop enable high: own serial stream routed internally to the receiver.
// [R14] Tx rate low: word latched only on the byte clock falling edge.
// [R15] Received word stays stable until the next presenting clock edge.
`timescale 1ns/10ps
`include "sppc_regs.vh"

// ----------------------------------------------------------------
// Transmit word FIFO
// ----------------------------------------------------------------
module sppc_fifo #(
	parameter W  = 10,
	parameter D  = 4,
	parameter AW = 2
) (
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire         ce_i,
	input  wire [W-1:0] in_data_i,
	input  wire         in_valid_i,
	output wire         in_ready_o,
	output wire [W-1:0] out_data_o,
	output wire         out_valid_o,
	input  wire         out_ready_i,
	output wire         full_o,
	output wire         empty_o
);
	reg [W-1:0] mem_q [0:D-1];
	reg [AW-1:0] wp_q;
	reg [AW-1:0] rp_q;
	reg [AW:0]   cnt_q;
	wire         push;
	wire         pop;

	assign full_o      = (cnt_q == D);
	assign empty_o     = (cnt_q == 0);
	assign in_ready_o  = ~full_o;
	assign out_valid_o = ~empty_o;
	assign out_data_o  = mem_q[rp_q];
	assign push        = in_valid_i & ~full_o;
	assign pop         = out_ready_i & ~empty_o;

	always @(posedge clk_i) begin
		if (rst_i) begin
			wp_q  <= {AW{1'b0}};
			rp_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else if (ce_i) begin
			if (push) begin
				mem_q[wp_q] <= in_data_i;
				wp_q        <= (wp_q == D-1) ? {AW{1'b0}} : wp_q + 1'b1;
			end
			if (pop)
				rp_q <= (rp_q == D-1) ? {AW{1'b0}} : rp_q + 1'b1;
			if (push & ~pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop & ~push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

// ----------------------------------------------------------------
// Parallel port control top
// ----------------------------------------------------------------
module sppc_top #(
	parameter LOS_CYCLES = `SPPC_LOS_CYCLES,
	parameter RBC_HALF   = `SPPC_RBC_HALF,
	parameter FIFO_DEPTH = 4
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        ce_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        transmit_byte_clock_i,
	input  wire [9:0]  tx_data_i,
	output reg  [1:0]  serial_data_o,
	output reg         serial_toggle_o,
	output reg         serial_drive_o,
	input  wire [1:0]  serial_data_i,
	input  wire        serial_toggle_i,
	output reg  [9:0]  rx_data_o,
	output reg         recovered_clock_a_o,
	output reg         recovered_clock_b_o,
	output reg         input_signal_loss_flag_o
);
	// ------------------------------------------------------------
	// Control register and pin synchronisers
	// ------------------------------------------------------------
	reg [`SPPC_CTRL_W-1:0] ctrl_q;
	reg [7:0]  ovf_q;
	reg [15:0] period_q;
	reg [15:0] pcnt_q;
	reg [2:0]  tbc_q;
	reg [9:0]  txs1_q;
	reg [9:0]  txs2_q;
	reg [9:0]  txs3_q;
	reg [9:0]  txs4_q;
	reg [2:0]  rxs1_q;
	reg [2:0]  rxs2_q;
	reg        rxt_q;
	wire       rx_rate    = ctrl_q[`SPPC_CTRL_RX_RATE];
	wire       tx_rate    = ctrl_q[`SPPC_CTRL_TX_RATE];
	wire       align_mode = ctrl_q[`SPPC_CTRL_ALIGN];
	wire       loop_en    = ctrl_q[`SPPC_CTRL_LOOP];
	wire       tbc_rise   = tbc_q[1] & ~tbc_q[2];
	wire       tbc_fall   = ~tbc_q[1] & tbc_q[2];
	// Both edges at full rate, falling only at half rate
	wire       tx_take    = tx_rate ? (tbc_rise | tbc_fall) : tbc_fall; // R7 R14

	always @(posedge clk_i) begin
		if (rst_i) begin
			tbc_q    <= 3'h0;
			txs1_q   <= 10'h000;
			txs2_q   <= 10'h000;
			txs3_q   <= 10'h000;
			txs4_q   <= 10'h000;
			rxs1_q   <= 3'h0;
			rxs2_q   <= 3'h0;
			rxt_q    <= 1'b0;
			period_q <= 16'h0000;
			pcnt_q   <= 16'h0000;
		end else if (ce_i) begin
			tbc_q  <= {tbc_q[1:0], transmit_byte_clock_i};
			txs1_q <= tx_data_i;
			txs2_q <= txs1_q;
			txs3_q <= txs2_q;
			txs4_q <= txs3_q;
			rxs1_q <= {serial_toggle_i, serial_data_i};
			rxs2_q <= rxs1_q;
			rxt_q  <= rxs2_q[2];
			// Byte clock period in system cycles, used as bit-rate reference
			if (tbc_rise) begin
				period_q <= pcnt_q + 16'h0001;
				pcnt_q   <= 16'h0000;
			end else if (pcnt_q != 16'hffff) begin
				pcnt_q <= pcnt_q + 16'h0001;
			end
		end
	end

	// ------------------------------------------------------------
	// Transmit FIFO
	// ------------------------------------------------------------
	wire [9:0] ff_data;
	wire       ff_valid;
	wire       ff_ready;
	wire       ff_full;
	wire       ff_empty;
	wire       ff_in_ready;
	reg        sh_load;

	assign ff_ready = sh_load;

	sppc_fifo #(
		.W  (`SPPC_WORD_W),
		.D  (FIFO_DEPTH),
		.AW (2)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		// Word launched before the edge sits mid-window in the oldest stage
		.in_data_i   (txs4_q),
		.in_valid_i  (tx_take),
		.in_ready_o  (ff_in_ready),
		.out_data_o  (ff_data),
		.out_valid_o (ff_valid),
		.out_ready_i (ff_ready),
		.full_o      (ff_full),
		.empty_o     (ff_empty)
	);

	// ------------------------------------------------------------
	// Serializer: ten pair strobes per byte clock period
	// ------------------------------------------------------------
	reg  [15:0] acc_q;
	reg  [9:0]  sh_q;
	reg  [3:0]  sh_left_q;
	reg  [1:0]  pair_q;
	reg         pair_stb_q;
	wire [15:0] acc_nx = acc_q + `SPPC_PAIRS_PER_PD;
	wire        bit_stb = (period_q != 16'h0000) && (acc_nx >= period_q); // R8
	wire [3:0]  step   = tx_rate ? 4'h2 : 4'h1;

	always @* begin
		sh_load = bit_stb && (sh_left_q == 4'h0);
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			acc_q      <= 16'h0000;
			sh_q       <= `SPPC_ALL_ONES;
			sh_left_q  <= 4'h0;
			pair_q     <= 2'h3;
			pair_stb_q <= 1'b0;
		end else if (ce_i) begin
			acc_q      <= bit_stb ? acc_nx - period_q : acc_nx;
			pair_stb_q <= 1'b0;
			if (sh_load & ff_valid) begin
				// Bit zero leaves first
				pair_q     <= tx_rate ? ff_data[1:0] : {1'b1, ff_data[0]}; // R11
				sh_q       <= tx_rate ? {2'h3, ff_data[9:2]} : {1'b1, ff_data[9:1]};
				sh_left_q  <= 4'ha - step;
				pair_stb_q <= 1'b1;
			end else if (bit_stb && sh_left_q != 4'h0) begin
				pair_q     <= tx_rate ? sh_q[1:0] : {1'b1, sh_q[0]}; // R11
				sh_q       <= tx_rate ? {2'h3, sh_q[9:2]} : {1'b1, sh_q[9:1]};
				// Clamp so a rate change in mid-word cannot step past zero
				sh_left_q  <= (sh_left_q > step) ? sh_left_q - step : 4'h0;
				pair_stb_q <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Serial output pins
	// ------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			serial_data_o   <= 2'h3;
			serial_toggle_o <= 1'b0;
			serial_drive_o  <= 1'b0;
		end else if (ce_i) begin
			serial_drive_o <= ~loop_en; // R6
			if (loop_en) begin
				serial_data_o <= 2'h3; // R5
			end else if (pair_stb_q) begin
				serial_data_o   <= pair_q;
				serial_toggle_o <= ~serial_toggle_o;
			end
		end
	end

	// ------------------------------------------------------------
	// Receive path: source select, loss detect, deserializer
	// ------------------------------------------------------------
	wire        ext_stb  = (rxs2_q[2] != rxt_q) & ~loop_en; // R6
	wire        rx_stb   = loop_en ? pair_stb_q : ext_stb; // R13
	wire [1:0]  rx_pair  = loop_en ? pair_q : rxs2_q[1:0]; // R13
	reg  [15:0] los_cnt_q;
	reg         loss_q;
	reg  [9:0]  des_q;
	reg  [3:0]  des_cnt_q;
	reg  [9:0]  pend_q;
	wire [3:0]  rstep    = rx_rate ? 4'h2 : 4'h1;
	wire [9:0]  des_nx   = rx_rate ? {rx_pair, des_q[9:2]} : {rx_pair[0], des_q[9:1]};

	always @(posedge clk_i) begin
		if (rst_i) begin
			los_cnt_q <= 16'h0000;
			loss_q    <= 1'b1;
			des_q     <= `SPPC_ALL_ONES;
			des_cnt_q <= 4'h0;
			pend_q    <= `SPPC_ALL_ONES;
		end else if (ce_i) begin
			if (rx_stb) begin
				los_cnt_q <= 16'h0000;
				loss_q    <= ctrl_q[`SPPC_CTRL_FLOSS];
			end else if (los_cnt_q == LOS_CYCLES - 1) begin
				loss_q <= 1'b1;
			end else begin
				los_cnt_q <= los_cnt_q + 16'h0001;
				loss_q    <= loss_q | ctrl_q[`SPPC_CTRL_FLOSS];
			end
			if (loss_q) begin
				des_cnt_q <= 4'h0;
			end
			if (rx_stb) begin
				// First bit received ends in bit zero
				des_q <= des_nx; // R12
				if (des_cnt_q + rstep >= 4'ha) begin
					pend_q    <= des_nx; // R12
					des_cnt_q <= 4'h0;
				end else begin
					des_cnt_q <= des_cnt_q + rstep;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Recovered byte clocks and word presentation
	// ------------------------------------------------------------
	reg  [7:0] rbc_cnt_q;
	reg        rbc_ph_q;
	wire       rbc_wrap = (rbc_cnt_q == RBC_HALF - 1);
	wire       rbc_mid  = (rbc_cnt_q == RBC_HALF / 2 - 1);
	// Next edge is a clock A rise while A is low
	wire       a_rises  = ~rbc_ph_q;
	wire       at_point = align_mode ? rbc_wrap : rbc_mid; // R3
	wire       present  = at_point & (rx_rate | a_rises); // R1 R2

	always @(posedge clk_i) begin
		if (rst_i) begin
			rbc_cnt_q                <= 8'h00;
			rbc_ph_q                 <= 1'b0;
			recovered_clock_a_o      <= 1'b0;
			recovered_clock_b_o      <= 1'b1;
			rx_data_o                <= `SPPC_ALL_ONES;
			input_signal_loss_flag_o <= 1'b1;
		end else if (ce_i) begin
			rbc_cnt_q <= rbc_wrap ? 8'h00 : rbc_cnt_q + 8'h01;
			if (rbc_wrap) begin
				rbc_ph_q            <= ~rbc_ph_q;
				recovered_clock_a_o <= ~rbc_ph_q; // R9
				recovered_clock_b_o <= rbc_ph_q; // R9
			end
			input_signal_loss_flag_o <= loss_q;
			// Word moves at a presenting point, or to all ones on loss
			if (loss_q)
				rx_data_o <= `SPPC_ALL_ONES; // R4
			else if (present)
				rx_data_o <= pend_q; // R15
		end
	end

	// ------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------
	wire       wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire [3:0] wb_ofs = {wb_adr_i[3:2], 2'b00};

	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q   <= `SPPC_CTRL_RST;
			ovf_q    <= 8'h00;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else if (ce_i) begin
			wb_ack_o <= wb_req;
			if (tx_take & ~ff_in_ready & (ovf_q != 8'hff))
				ovf_q <= ovf_q + 8'h01;
			if (wb_req & wb_we_i & wb_sel_i[0] & (wb_ofs == `SPPC_CTRL_OFS))
				ctrl_q <= wb_dat_i[`SPPC_CTRL_W-1:0];
			// A word dropped in the clear cycle still counts
			if (wb_req & wb_we_i & wb_sel_i[1] & (wb_ofs == `SPPC_STATUS_OFS))
				ovf_q <= {7'h00, tx_take & ~ff_in_ready};
			if (wb_req & ~wb_we_i) begin
				case (wb_ofs)
					`SPPC_CTRL_OFS: wb_dat_o <= {27'h0, ctrl_q};
					`SPPC_STATUS_OFS: wb_dat_o <= {16'h0, ovf_q, 5'h0,
						ff_empty, ff_full, loss_q};
					`SPPC_RXWORD_OFS: wb_dat_o <= {22'h0, rx_data_o};
					`SPPC_PERIOD_OFS: wb_dat_o <= {16'h0, period_q};
					default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end
endmodule

// File: sim/sppc_props.sv
`timescale 1ns/10ps
module sppc_props (
	input wire        clk_i,
	input wire        rst_i,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [3:0]  wb_adr_i,
	input wire [3:0]  wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire        wb_ack_o,
	input wire [1:0]  serial_data_o,
	input wire        serial_drive_o,
	input wire [9:0]  rx_data_o,
	input wire        recovered_clock_a_o,
	input wire        recovered_clock_b_o,
	input wire        input_signal_loss_flag_o
);
	// ----------------------------------------------------------------
	// Shadow of the control register, taken at the ack edge
	// ----------------------------------------------------------------
	reg [4:0] ctrl_q;
	always @(posedge clk_i)
		if (rst_i)
			ctrl_q <= 5'h00;
		else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[3:2] == 2'h0)
			ctrl_q <= wb_dat_i[4:0];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	loop_static_a: assert property (
		ctrl_q[3] [*3] |-> serial_data_o == 2'h3 && !serial_drive_o)
		else $error("serial output not static in loop mode");
	drive_on_a: assert property (
		!ctrl_q[3] [*3] |-> serial_drive_o)
		else $error("serial output not driven");
	loss_ones_a: assert property (
		input_signal_loss_flag_o && $past(input_signal_loss_flag_o) |-> rx_data_o == 10'h3ff)
		else $error("rx word not all ones during loss");
	clk_opposite_a: assert property (
		recovered_clock_a_o != recovered_clock_b_o)
		else $error("recovered clocks not in opposite phase");
	rate_low_a: assert property (
		ctrl_q == 5'h04 && $stable(ctrl_q) && $changed(rx_data_o) && !input_signal_loss_flag_o
		&& !$past(input_signal_loss_flag_o) |-> $rose(recovered_clock_a_o))
		else $error("rx word changed off clock a rise");
	rate_high_a: assert property (
		ctrl_q[2] && ctrl_q[0] && $stable(ctrl_q) && $changed(rx_data_o)
		&& !input_signal_loss_flag_o && !$past(input_signal_loss_flag_o)
		|-> $changed(recovered_clock_a_o))
		else $error("rx word changed off a clock edge");
	ack_next_a: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus ack late");
	ack_pulse_a: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("bus ack longer than one cycle");
endmodule

bind sppc_top sppc_props u_props (.*);

// File: sim/sppc_mac_model.sv
`timescale 1ns/10ps
module sppc_mac_model (
	input  wire       fast_i,
	input  wire [9:0] word_i,
	output reg        byte_clk_o,
	output reg  [9:0] tx_data_o
);
	// ----------------------------------------------------------------
	// Byte clock, new word launched at each of its edges
	// ----------------------------------------------------------------
	initial begin
		byte_clk_o = 1'b0;
		tx_data_o  = 10'h000;
		#1.3;
		forever begin
			#(fast_i ? 16 : 32);
			byte_clk_o = ~byte_clk_o;
			tx_data_o  = word_i;
		end
	end
endmodule

// File: sim/sppc_top_tb.sv
`timescale 1ns/10ps
module sppc_top_tb;
	localparam logic [9:0] W = 10'h00b;
	logic        clk_i    = 1'b0;
	logic        rst_i    = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i  = 1'b0;
	logic [3:0]  wb_adr_i = 4'h0;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic        fast     = 1'b0;
	logic        ce       = 1'b1;
	int          fails    = 0;
	int          samples_checked = 0;
	wire  [31:0] wb_dat_o;
	wire  [9:0]  tx_data, rx_data_o;
	wire  [1:0]  serial_data_o;
	wire         wb_ack_o, bclk, serial_toggle_o, serial_drive_o, clk_a, clk_b, loss;

	// ----------------------------------------------------------------
	// Design, far side, and external serial loop
	// ----------------------------------------------------------------
	sppc_mac_model u_mac (.fast_i(fast), .word_i(W), .byte_clk_o(bclk), .tx_data_o(tx_data));
	sppc_top u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.transmit_byte_clock_i(bclk), .tx_data_i(tx_data),
		.serial_data_o(serial_data_o), .serial_toggle_o(serial_toggle_o),
		.serial_drive_o(serial_drive_o),
		.serial_data_i(serial_drive_o ? serial_data_o : 2'h3),
		.serial_toggle_i(serial_toggle_o),
		.rx_data_o(rx_data_o), .recovered_clock_a_o(clk_a),
		.recovered_clock_b_o(clk_b), .input_signal_loss_flag_o(loss));

	initial forever #2 clk_i = ~clk_i;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
			input logic [31:0] wd, output logic [31:0] rd);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= wd;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1)
			@(posedge clk_i);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [31:0] d);
		logic [31:0] x;
		wb(1'b1, 4'h0, 4'hf, d, x);
	endtask

	function automatic logic rot_ok(input logic [9:0] v);
		logic [9:0] r = W;
		rot_ok = 1'b0;
		for (int i = 0; i < 10; i++) begin
			if (v === r)
				rot_ok = 1'b1;
			r = {r[8:0], r[9]};
		end
	endfunction

	task automatic t_reset;
		logic [31:0] d;
		wb(1'b0, 4'h0, 4'hf, 32'h0, d);
		chk(d, 32'h0);
		wb(1'b0, 4'h4, 4'hf, 32'h0, d);
		chk(d, 32'h5);
		wb(1'b0, 4'h8, 4'hf, 32'h0, d);
		chk(d, 32'h3ff);
		$display("t_reset done");
	endtask

	task automatic t_stream(input logic [31:0] ctrl);
		logic [31:0] d;
		logic [19:0] s   = 20'h0;
		logic        hit = 1'b0;
		logic        tq;
		int          k   = 0;
		wr(ctrl);
		repeat (300) @(posedge clk_i);
		tq = serial_toggle_o;
		repeat (160) begin
			@(posedge clk_i);
			if (serial_toggle_o !== tq) begin
				k++;
				if (ctrl[1])
					s = {s[17:0], serial_data_o[0], serial_data_o[1]};
				else
					s = {s[18:0], serial_data_o[0]};
			end
			tq = serial_toggle_o;
		end
		for (int i = 0; i < 17; i++)
			if (s[i +: 4] === 4'b1101)
				hit = 1'b1;
		chk(k > 98 && k < 102, 1);
		chk(hit, 1);
		chk(rot_ok(rx_data_o), 1);
		chk(loss, 0);
		wb(1'b0, 4'hc, 4'hf, 32'h0, d);
		chk(d, 32'h10);
		$display("t_stream done");
	endtask

	task automatic t_loop;
		wr(32'hf);
		repeat (300) @(posedge clk_i);
		chk(serial_data_o, 32'h3);
		chk(serial_drive_o, 0);
		chk(rot_ok(rx_data_o), 1);
		$display("t_loop done");
	endtask

	task automatic t_loss;
		wr(32'h14);
		repeat (20) @(posedge clk_i);
		chk(rx_data_o, 32'h3ff);
		chk(loss, 1);
		wr(32'h4);
		repeat (100) @(posedge clk_i);
		chk(loss, 0);
		$display("t_loss done");
	endtask

	task automatic t_fifo;
		logic [31:0] d;
		fast <= 1'b1;
		repeat (400) @(posedge clk_i);
		wb(1'b0, 4'h4, 4'hf, 32'h0, d);
		$display("overflow count %0d full %0b", d[15:8], d[1]);
		chk(d[15:8] != 8'h00, 1);
		fast <= 1'b0;
		repeat (300) @(posedge clk_i);
		wb(1'b1, 4'h4, 4'h2, 32'h0, d);
		wb(1'b0, 4'h4, 4'hf, 32'h0, d);
		chk(d[15:8], 0);
		$display("t_fifo done");
	endtask

	task automatic t_hold;
		logic [9:0] r;
		logic       a;
		logic       t;
		ce <= 1'b0;
		@(posedge clk_i);
		r = rx_data_o;
		a = clk_a;
		t = serial_toggle_o;
		repeat (20) @(posedge clk_i);
		chk(rx_data_o, r);
		chk(clk_a, a);
		chk(serial_toggle_o, t);
		ce <= 1'b1;
		@(posedge clk_i);
		$display("t_hold done");
	endtask

	task automatic wrap_up;
		$display("compared %0d mismatched %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#100000;
		fails++;
		wrap_up;
	end

	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_stream(32'h7);
		t_stream(32'h3);
		t_loop;
		t_loss;
		t_stream(32'h4);
		t_fifo;
		t_hold;
		wrap_up;
	end
endmodule
